// *** rtl/eac_pkg.sv ***
// package for the nonvolatile array access controller: map, fields, timing
// Notes on behaviour
// - 96 words of 16 bits, single-correct double-detect
// - only the application cpu reaches the array
// - byte reads allowed, writes only whole words
// - 5 ms busy timed from 250 kHz tick
// - each write or erase starts busy period
// - busy period never stalls either cpu
// - array access while busy raises exception interrupt
// - array read takes 4 clocks via wait states
// - bus write starts write or erase per select
// - address and data latched, bus cycle ends immediately
// - busy flag reads 1 while running, else 0
// - done interrupt on busy falling, when enabled
// - write and erase only in system mode
// - write permit resets 0; blocked op raises protection
// - control port: busy bit 7, select bits 1:0
// - select 00 write, 01 erase; block write fills array
// - block erase sets every array bit to 1
// - write permit is bit 6 of system control
// - status: double error bit 7, corrected bit 6
package eac_pkg;
  localparam int ADDR_W = 18;
  localparam int WORDS  = 96;
  localparam int DATA_W = 16;
  localparam int CODE_W = 22;
  localparam int IDX_W  = 7;
  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_SYS_CTRL  = 16'he000;
  localparam logic [15:0] IDX_NV_CTRL   = 16'he001;
  localparam logic [15:0] IDX_NV_STATUS = 16'he002;
  localparam logic [15:0] IDX_NV_IRQ_EN = 16'he003;
  localparam logic [ADDR_W-1:0] ADDR_SYS_CTRL  = {IDX_SYS_CTRL, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_NV_CTRL   = {IDX_NV_CTRL, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_NV_STATUS = {IDX_NV_STATUS, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_NV_IRQ_EN = {IDX_NV_IRQ_EN, 2'b00};
  localparam logic [ADDR_W-1:0] ARRAY_TOP      = 18'h00180;
  // field positions
  localparam int SYS_WE_BIT  = 6;
  localparam int BUSY_BIT    = 7;
  localparam int DED_BIT     = 7;
  localparam int SEC_BIT     = 6;
  localparam int DONE_EN_BIT = 0;
  localparam logic       WE_RESET    = 1'b0;
  localparam logic [1:0] OPSEL_RESET = 2'b00;
  // timing
  localparam int MCLK_HZ      = 40_000_000;
  localparam int TICK_HZ      = 250_000;
  localparam int TICK_DIV     = MCLK_HZ / TICK_HZ;
  localparam int BUSY_US      = 5000;
  localparam int BUSY_TICKS   = BUSY_US * (TICK_HZ / 1000) / 1000;
  localparam int READ_WAIT    = 4;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [1:0] RESP_DECERR = 2'b11;

  typedef enum logic [1:0] {
    OP_WRITE     = 2'b00,
    OP_ERASE     = 2'b01,
    OP_BLK_WRITE = 2'b10,
    OP_BLK_ERASE = 2'b11
  } eac_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } eac_state_t;

  typedef struct packed {
    eac_op_t               op;
    logic [IDX_W-1:0]      idx;
    logic [DATA_W-1:0]     data;
  } eac_pend_t;
endpackage

// *** rtl/eac_top.sv ***
// nonvolatile array access controller with axi4-lite slave port
`timescale 1ns/1ps
module eac_top #(
  parameter int BUSY_TICKS = eac_pkg::BUSY_TICKS,
  parameter int TICK_DIV   = eac_pkg::TICK_DIV
) (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic [eac_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]                s_axi_awprot,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [eac_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]                s_axi_arprot,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  output logic                           nv_busy_flag,
  output logic                           nv_done_irq,
  output logic                           nv_exception_irq,
  output logic                           nv_protection_irq
);
  localparam int AW = eac_pkg::ADDR_W;

  // hamming over positions 1..21, overall parity in bit 0
  function automatic logic [eac_pkg::CODE_W-1:0] secded_enc(input logic [15:0] d);
    logic [eac_pkg::CODE_W-1:0] c;
    int k;
    c = '0;
    k = 0;
    for (int i = 1; i < eac_pkg::CODE_W; i++) begin
      if ((i & (i - 1)) != 0) begin
        c[i] = d[k];
        k++;
      end
    end
    for (int p = 0; p < 5; p++) begin
      for (int i = 1; i < eac_pkg::CODE_W; i++) begin
        if (i[p] && (i != (1 << p))) c[1 << p] = c[1 << p] ^ c[i];
      end
    end
    c[0] = ^c[eac_pkg::CODE_W-1:1];
    return c;
  endfunction

  // returns {double, single, data}; an all-ones word is the erased state
  function automatic logic [17:0] secded_dec(input logic [eac_pkg::CODE_W-1:0] cw);
    logic [eac_pkg::CODE_W-1:0] c;
    logic [4:0]                 syn;
    logic [15:0]                d;
    logic                       par;
    logic                       sgl;
    logic                       dbl;
    int                         k;
    c   = cw;
    syn = '0;
    d   = '0;
    k   = 0;
    for (int i = 1; i < eac_pkg::CODE_W; i++) begin
      if (c[i]) syn = syn ^ i[4:0];
    end
    par = ^c;
    sgl = par;
    dbl = !par && (syn != 5'h00);
    if (&cw) begin
      sgl = 1'b0;
      dbl = 1'b0;
    end
    if (sgl && (syn < 5'd22)) c[syn] = !c[syn];
    for (int i = 1; i < eac_pkg::CODE_W; i++) begin
      if ((i & (i - 1)) != 0) begin
        d[k] = c[i];
        k++;
      end
    end
    return {dbl, sgl, d};
  endfunction

  // storage: 96 protected words
  logic [eac_pkg::CODE_W-1:0] mem [eac_pkg::WORDS];

  // control and status state
  logic                   write_permit;
  logic [1:0]             op_select;
  logic                   done_irq_en;
  logic                   ded_flag;
  logic                   sec_flag;
  eac_pkg::eac_state_t    state;
  eac_pkg::eac_pend_t     pend;
  logic [7:0]             tick_cnt;
  logic [11:0]            busy_cnt;
  logic                   tick;

  // write channel capture
  logic [AW-1:0]          aw_addr;
  logic                   aw_priv;
  logic [31:0]            w_data;
  logic [3:0]             w_strb;
  logic                   wr_go;

  // read channel capture
  logic [AW-1:0]          ar_addr;
  logic [2:0]             rd_cnt;
  logic                   rd_run;

  // write decode
  wire               w_arr     = aw_addr < eac_pkg::ARRAY_TOP;
  wire [6:0]         w_idx     = aw_addr[8:2];
  wire               w_full    = w_strb[1:0] == 2'b11;
  wire               w_lane0   = w_strb[0];
  wire               w_is_sys  = aw_addr == eac_pkg::ADDR_SYS_CTRL;
  wire               w_is_ctl  = aw_addr == eac_pkg::ADDR_NV_CTRL;
  wire               w_is_sta  = aw_addr == eac_pkg::ADDR_NV_STATUS;
  wire               w_is_ien  = aw_addr == eac_pkg::ADDR_NV_IRQ_EN;
  wire               w_reg     = w_is_sys | w_is_ctl | w_is_sta | w_is_ien;
  wire               busy      = state == eac_pkg::ST_BUSY;
  wire               w_arr_go  = wr_go && w_arr;
  wire               w_exc     = w_arr_go && busy;
  wire               w_ok_mode = aw_priv && w_full;
  wire               w_prot    = w_arr_go && !busy && w_ok_mode && !write_permit;
  wire               w_start   = w_arr_go && !busy && w_ok_mode && write_permit;
  wire               w_reg_ok  = wr_go && w_reg && aw_priv && w_lane0;

  // read decode
  wire               r_arr     = ar_addr < eac_pkg::ARRAY_TOP;
  wire [6:0]         r_idx     = ar_addr[8:2];
  wire [17:0]        r_dec     = secded_dec(mem[r_idx]);
  wire               r_done    = rd_run && (rd_cnt == 3'(eac_pkg::READ_WAIT - 1));
  wire               r_exc     = r_done && r_arr && busy;
  wire               r_good    = r_done && r_arr && !busy;
  wire               busy_end  = busy && tick && (busy_cnt == 12'(BUSY_TICKS - 1));

  // sticky error flags: a new detection wins over a clear
  wire next_ded = (r_good && r_dec[17]) ||
                  (ded_flag && !(w_reg_ok && w_is_sta && w_data[eac_pkg::DED_BIT]));
  wire next_sec = (r_good && r_dec[16]) ||
                  (sec_flag && !(w_reg_ok && w_is_sta && w_data[eac_pkg::SEC_BIT]));

  // read data selection
  wire [7:0] ctl_rd = {busy, 5'h00, op_select};
  wire [7:0] sys_rd = {1'b0, write_permit, 6'h00};
  wire [7:0] sta_rd = {ded_flag, sec_flag, 6'h00};
  wire       r_reg  = (ar_addr == eac_pkg::ADDR_SYS_CTRL) || (ar_addr == eac_pkg::ADDR_NV_CTRL) ||
                      (ar_addr == eac_pkg::ADDR_NV_STATUS) || (ar_addr == eac_pkg::ADDR_NV_IRQ_EN);
  wire [31:0] next_rdata =
      r_arr                                 ? {16'h0000, r_dec[15:0]} :
      (ar_addr == eac_pkg::ADDR_SYS_CTRL)   ? {24'h000000, sys_rd} :
      (ar_addr == eac_pkg::ADDR_NV_CTRL)    ? {24'h000000, ctl_rd} :
      (ar_addr == eac_pkg::ADDR_NV_STATUS)  ? {24'h000000, sta_rd} :
      (ar_addr == eac_pkg::ADDR_NV_IRQ_EN)  ? {31'h00000000, done_irq_en} : 32'h00000000;
  wire [1:0] next_rresp =
      r_exc ? eac_pkg::RESP_SLVERR : (r_arr || r_reg) ? eac_pkg::RESP_OKAY : eac_pkg::RESP_DECERR;
  wire [1:0] next_bresp =
      w_start || w_reg_ok ? eac_pkg::RESP_OKAY :
      (w_arr || w_reg)    ? eac_pkg::RESP_SLVERR : eac_pkg::RESP_DECERR;

  // 250 kHz tick from the master clock, runs only while busy
  always_ff @(posedge aclk) begin
    if (!aresetn || !busy || tick) begin
      tick_cnt <= 8'h00;
    end else begin
      tick_cnt <= tick_cnt + 8'h01;
    end
  end
  assign tick = busy && (tick_cnt == 8'(TICK_DIV - 1));

  // write address and data taken together, in whichever order they came
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      wr_go         <= 1'b0;
    end else begin
      s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !wr_go && !s_axi_bvalid;
      s_axi_wready  <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !wr_go && !s_axi_bvalid;
      wr_go         <= s_axi_awready && s_axi_awvalid;
    end
  end

  // payload latch, no reset needed for data
  always_ff @(posedge aclk) begin
    if (s_axi_awready && s_axi_awvalid) begin
      aw_addr <= s_axi_awaddr;
      aw_priv <= s_axi_awprot[0];
      w_data  <= s_axi_wdata;
      w_strb  <= s_axi_wstrb;
    end
  end

  // write response, one cycle after the capture; never waits on busy
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= eac_pkg::RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= next_bresp;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // software registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      write_permit <= eac_pkg::WE_RESET;
      op_select    <= eac_pkg::OPSEL_RESET;
      done_irq_en  <= 1'b0;
      ded_flag     <= 1'b0;
      sec_flag     <= 1'b0;
    end else begin
      ded_flag <= next_ded;
      sec_flag <= next_sec;
      if (w_reg_ok && w_is_sys) write_permit <= w_data[eac_pkg::SYS_WE_BIT];
      if (w_reg_ok && w_is_ctl) op_select <= w_data[1:0];
      if (w_reg_ok && w_is_ien) done_irq_en <= w_data[eac_pkg::DONE_EN_BIT];
    end
  end

  // busy sequencer: latch the job, count the delay, commit at the end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state    <= eac_pkg::ST_IDLE;
      busy_cnt <= 12'h000;
      pend     <= '0;
    end else begin
      case (state)
        eac_pkg::ST_IDLE: begin
          busy_cnt <= 12'h000;
          if (w_start) begin
            pend  <= '{op: eac_pkg::eac_op_t'(op_select), idx: w_idx, data: w_data[15:0]};
            state <= eac_pkg::ST_BUSY;
          end
        end
        eac_pkg::ST_BUSY: begin
          if (busy_end) begin
            state <= eac_pkg::ST_IDLE;
          end else if (tick) begin
            busy_cnt <= busy_cnt + 12'h001;
          end
        end
        default: state <= eac_pkg::ST_IDLE;
      endcase
    end
  end

  // array contents change only when the delay has run out
  always_ff @(posedge aclk) begin
    if (busy_end) begin
      for (int i = 0; i < eac_pkg::WORDS; i++) begin
        case (pend.op)
          eac_pkg::OP_WRITE:     if (pend.idx == 7'(i)) mem[i] <= secded_enc(pend.data);
          eac_pkg::OP_ERASE:     if (pend.idx == 7'(i)) mem[i] <= '1;
          eac_pkg::OP_BLK_WRITE: mem[i] <= secded_enc(pend.data);
          default:               mem[i] <= '1;
        endcase
      end
    end
  end

  // read: address taken, then fixed wait states before the answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      rd_run        <= 1'b0;
      rd_cnt        <= 3'h0;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !rd_run && !s_axi_rvalid;
      if (s_axi_arready && s_axi_arvalid) begin
        rd_run <= 1'b1;
        rd_cnt <= 3'h0;
      end else if (r_done) begin
        rd_run <= 1'b0;
      end else if (rd_run) begin
        rd_cnt <= rd_cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (s_axi_arready && s_axi_arvalid) ar_addr <= s_axi_araddr;
  end

  // read response; arprot is not checked since reads are not privileged
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= eac_pkg::RESP_OKAY;
    end else if (r_done) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= r_exc ? 32'h00000000 : next_rdata;
      s_axi_rresp  <= next_rresp;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // interrupt pulses and busy pin; the pin drops at the very edge that ends the
  // delay, so the done pulse sits on its falling edge and not a cycle before
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nv_busy_flag      <= 1'b0;
      nv_done_irq       <= 1'b0;
      nv_exception_irq  <= 1'b0;
      nv_protection_irq <= 1'b0;
    end else begin
      nv_busy_flag      <= (busy && !busy_end) || w_start;
      nv_done_irq       <= busy_end && done_irq_en;
      nv_exception_irq  <= w_exc || r_exc;
      nv_protection_irq <= w_prot;
    end
  end
endmodule

// *** testbench/eac_assertions.sv ***
// checker: answer timing, busy span and event pulses of the controller
`timescale 1ns/1ps
module eac_assertions #(
  parameter int BUSY_TICKS = 8,
  parameter int TICK_DIV   = 8
) (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic [1:0] s_axi_bresp,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic [1:0] s_axi_rresp,
  input wire logic       nv_busy_flag,
  input wire logic       nv_done_irq,
  input wire logic       nv_exception_irq,
  input wire logic       nv_protection_irq
);
  localparam int LO = (BUSY_TICKS - 1) * TICK_DIV;
  localparam int HI = BUSY_TICKS * TICK_DIV + 2;
  localparam logic [1:0] ERR = eac_pkg::RESP_SLVERR;
  logic [31:0] busy_cnt;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // busy span; tick phase restarts at zero with busy, yet a window and not one figure
  always_ff @(posedge aclk) begin
    busy_cnt <= (!aresetn || !nv_busy_flag) ? 32'h0 : busy_cnt + 32'h1;
  end
  // answer shapes after a write or a read handshake
  sequence wr_ans_s;
    !s_axi_bvalid [*2] ##1 s_axi_bvalid;
  endsequence
  sequence rd_ans_s;
    !s_axi_rvalid [*5] ##1 s_axi_rvalid;
  endsequence
  ready_pair_a: assert property (s_axi_awready == s_axi_wready)
    else $error("ready pair split");
  wr_ans_a: assert property (s_axi_awready |-> wr_ans_s)
    else $error("write answer timing");
  rd_wait_a: assert property (s_axi_arready |-> rd_ans_s)
    else $error("read wait count");
  busy_rise_a: assert property ($rose(nv_busy_flag) |->
    $rose(s_axi_bvalid) && s_axi_bresp == eac_pkg::RESP_OKAY) else $error("busy no accept");
  busy_len_a: assert property ($fell(nv_busy_flag) |-> busy_cnt >= LO && busy_cnt <= HI)
    else $error("busy span");
  done_pulse_a: assert property (nv_done_irq |->
    !nv_busy_flag && ($past(nv_busy_flag) || $past(nv_busy_flag, 2))) else $error("done pulse");
  exc_pulse_a: assert property (nv_exception_irq |->
    s_axi_rvalid && s_axi_rresp == ERR || s_axi_bvalid && s_axi_bresp == ERR) else $error("exc");
  prot_pulse_a: assert property (nv_protection_irq |->
    s_axi_bvalid && s_axi_bresp == ERR && !nv_busy_flag) else $error("protection pulse");
endmodule

// *** testbench/eac_cpu.sv ***
// application cpu model: axi4-lite master, one write and one read at a time
`timescale 1ns/1ps
module eac_cpu (
  input  wire logic        aclk,
  output logic [17:0]      s_axi_awaddr,
  output logic [2:0]       s_axi_awprot,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  output logic             s_axi_bready,
  input  wire logic        s_axi_bvalid,
  input  wire logic [1:0]  s_axi_bresp,
  output logic [17:0]      s_axi_araddr,
  output logic [2:0]       s_axi_arprot,
  output logic             s_axi_arvalid,
  output logic             s_axi_rready,
  input  wire logic        s_axi_arready,
  input  wire logic        s_axi_rvalid,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp
);
  // readies held high: every answer is taken at the edge it shows
  initial begin
    {s_axi_awaddr, s_axi_awprot, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_wvalid, s_axi_araddr, s_axi_arprot, s_axi_arvalid} = '0;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
  end
  // address and data offered together, both taken in one edge
  task automatic wr(input logic [17:0] a, input logic [15:0] d, input logic p,
                    input logic [3:0] s, output logic [1:0] r);
    {s_axi_awaddr, s_axi_awprot, s_axi_wdata, s_axi_wstrb} <= {a, 2'b00, p, 16'h0, d, s};
    {s_axi_awvalid, s_axi_wvalid} <= 2'b11;
    // each channel held until its own ready, whatever order the slave takes them
    fork
      begin
        do @(posedge aclk); while (s_axi_awready !== 1'b1);
        s_axi_awvalid <= 1'b0;
      end
      begin
        do @(posedge aclk); while (s_axi_wready !== 1'b1);
        s_axi_wvalid <= 1'b0;
      end
    join
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
  endtask
  // read; waits out inserted wait states without assuming a count
  task automatic rd(input logic [17:0] a, output logic [31:0] d, output logic [1:0] r);
    {s_axi_araddr, s_axi_arprot, s_axi_arvalid} <= {a, 3'b001, 1'b1};
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    {d, r} = {s_axi_rdata, s_axi_rresp};
  endtask
endmodule

// *** testbench/testbench.sv ***
// self-checking bench: cpu model drives the controller over axi4-lite
`timescale 1ns/1ps
module testbench;
  localparam int BUSY_TICKS = 8;
  localparam int TICK_DIV   = 8;
  localparam logic [17:0] SYS = eac_pkg::ADDR_SYS_CTRL;
  localparam logic [17:0] CTL = eac_pkg::ADDR_NV_CTRL;
  localparam logic [17:0] STA = eac_pkg::ADDR_NV_STATUS;
  localparam logic [1:0]  OK  = eac_pkg::RESP_OKAY;
  localparam logic [1:0]  ERR = eac_pkg::RESP_SLVERR;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [17:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        s_axi_wready;
  logic        nv_busy_flag, nv_done_irq, nv_exception_irq, nv_protection_irq;
  int          n_errors = 0;
  int          cmp_count = 0;
  int          n_done = 0;
  int          n_exc = 0;
  int          n_prot = 0;
  always #12.5 aclk = ~aclk;
  eac_top #(.BUSY_TICKS(BUSY_TICKS), .TICK_DIV(TICK_DIV)) u_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .nv_busy_flag, .nv_done_irq,
    .nv_exception_irq, .nv_protection_irq);
  eac_cpu u_cpu (
    .aclk, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bready, .s_axi_bvalid,
    .s_axi_bresp, .s_axi_araddr,
    .s_axi_arprot, .s_axi_arvalid, .s_axi_rready, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rdata, .s_axi_rresp);
  // one-cycle pulses tallied at every edge
  always @(posedge aclk) begin
    if (nv_done_irq === 1'b1) n_done++;
    if (nv_exception_irq === 1'b1) n_exc++;
    if (nv_protection_irq === 1'b1) n_prot++;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask
  task automatic wchk(input string n, input logic [17:0] a, input logic [15:0] d,
                      input logic p, input logic [3:0] s, input logic [1:0] er);
    logic [1:0] r;
    u_cpu.wr(a, d, p, s, r);
    chk(n, {30'h0, er}, {30'h0, r});
  endtask
  task automatic rchk(input string n, input logic [17:0] a, input logic [31:0] ed,
                      input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    u_cpu.rd(a, d, r);
    chk(n, ed, d);
    chk(n, {30'h0, er}, {30'h0, r});
  endtask
  function automatic logic [17:0] wa(input int i);
    return 18'(i * 4);
  endfunction
  // reset values, unmapped space, then each refusal of a change
  task automatic t_regs;
    rchk("ctl", CTL, 32'h0, OK);
    rchk("sys", SYS, 32'h0, OK);
    rchk("status", STA, 32'h0, OK);
    rchk("unmapped", 18'h3fff0, 32'h0, eac_pkg::RESP_DECERR);
    wchk("no permit", wa(3), 16'h1111, 1'b1, 4'hf, ERR);
    wchk("permit", SYS, 16'h0040, 1'b1, 4'h1, OK);
    rchk("permit", SYS, 32'h40, OK);
    wchk("user mode", wa(3), 16'h2222, 1'b0, 4'hf, ERR);
    wchk("byte write", wa(3), 16'h3333, 1'b1, 4'h1, ERR);
    wchk("reserved", CTL, 16'h00ff, 1'b1, 4'h1, OK);
    rchk("reserved", CTL, 32'h03, OK);
    wchk("irq en", eac_pkg::ADDR_NV_IRQ_EN, 16'h0001, 1'b1, 4'h1, OK);
    chk("prot irqs", 32'd1, n_prot);
    chk("idle", 32'h0, {31'h0, nv_busy_flag});
  endtask
  // every operation code; array touched while busy; whole-array effects
  task automatic t_ops;
    logic [1:0]  op [4] = '{2'b11, 2'b00, 2'b01, 2'b10};
    int          at [4] = '{0, 5, 5, 0};
    logic [15:0] dt [4] = '{16'h0000, 16'ha5c3, 16'h0000, 16'h1234};
    logic [15:0] e95 [4] = '{16'hffff, 16'hffff, 16'hffff, 16'h1234};
    logic [15:0] e5 [4] = '{16'hffff, 16'ha5c3, 16'hffff, 16'h1234};
    for (int k = 0; k < 4; k++) begin
      wchk("op", CTL, {14'h0, op[k]}, 1'b1, 4'h1, OK);
      wchk("array op", wa(at[k]), dt[k], 1'b1, 4'hf, OK);
      chk("busy", 32'h1, {31'h0, nv_busy_flag});
      rchk("ctl busy", CTL, {24'h0, 6'h20, op[k]}, OK);
      rchk("read busy", wa(5), 32'h0, ERR);
      wchk("write busy", wa(5), 16'h0, 1'b1, 4'hf, ERR);
      for (int i = 0; i < 2000 && nv_busy_flag !== 1'b0; i++) begin
        @(posedge aclk);
      end
      chk("busy end", 32'h0, {31'h0, nv_busy_flag});
      rchk("word 95", wa(95), {16'h0, e95[k]}, OK);
      rchk("word 5", wa(5), {16'h0, e5[k]}, OK);
    end
    chk("done irqs", 32'd4, n_done);
    chk("exceptions", 32'd8, n_exc);
    rchk("status", STA, 32'h0, OK);
  endtask
  task automatic complete_run;
    $display("compares %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs;
    t_ops;
    complete_run;
  end
  // watchdog: the run needs well under a tenth of this span
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    complete_run;
  end
endmodule
bind eac_top eac_assertions #(.BUSY_TICKS(BUSY_TICKS), .TICK_DIV(TICK_DIV)) u_chk (
  .aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bresp,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rresp, .nv_busy_flag, .nv_done_irq,
  .nv_exception_irq, .nv_protection_irq);
